// *** src/brt_regs.svh ***
// Register map, field positions, reset values and response codes of the coding control block
`ifndef BRT_REGS_SVH
`define BRT_REGS_SVH
`define BRT_A_SD_CFG      8'h00
`define BRT_A_CODING_CFG  8'h04
`define BRT_A_CODING_ST   8'h08
`define BRT_A_PAT_CFG     8'h0C
`define BRT_A_SEED_AU     8'h10
`define BRT_A_SEED_AL     8'h14
`define BRT_A_SEED_BU     8'h18
`define BRT_A_SEED_BL     8'h1C
`define BRT_A_TXP_U       8'h20
`define BRT_A_TXP_L       8'h24
`define BRT_A_RXP_U       8'h28
`define BRT_A_RXP_L       8'h2C
`define BRT_A_ERR_CNT     8'h30
`define BRT_A_LPI_ST      8'h34
`define BRT_A_WAKE_CNT    8'h38
`define BRT_A_FC_CFG      8'h3C
`define BRT_A_FC_ST       8'h40
`define BRT_A_FC_FLAGS    8'h44
`define BRT_A_FIX_CNT     8'h48
`define BRT_A_UNF_CNT     8'h4C
`define BRT_A_FIX_LIM     8'h50
`define BRT_A_UNF_LIM     8'h54
`define BRT_F_SD_REACT    0
`define BRT_F_DET_LEVEL   1
`define BRT_F_SD_SRC      2
`define BRT_F_LOOP        0
`define BRT_F_TX_TEST     1
`define BRT_F_RX_TEST     2
`define BRT_F_FC_ON       0
`define BRT_F_FC_TXFLIP   1
`define BRT_F_FC_RXFLIP   2
`define BRT_F_FC_ERRIND   3
`define BRT_F_FC_CNTRST   4
`define BRT_F_LOCK_FLAG   0
`define BRT_F_FIX_FLAG    1
`define BRT_F_UNF_FLAG    2
`define BRT_RST_SD_CFG    3'h3
`define BRT_RST_LIMIT     32'h0000_0100
`define BRT_RESP_OKAY     2'h0
`define BRT_RESP_SLVERR   2'h2
`endif

// *** src/brt_pkg.sv ***
// Types shared by the coding control block and its pattern engine
package brt_pkg;
	typedef enum logic [1:0] {
		BRT_PAT_SQUARE = 2'h0,
		BRT_PAT_PSEUDO = 2'h1,
		BRT_PAT_PRBS31 = 2'h2,
		BRT_PAT_USER   = 2'h3
	} brt_pat_t;
	typedef enum logic [1:0] {
		BRT_W_IDLE = 2'b01,
		BRT_W_RESP = 2'b10
	} brt_wst_t;
	typedef struct packed {
		logic [57:0] scr;
		logic [30:0] prbs;
		logic [6:0]  blk;
		logic [1:0]  phase;
		logic [3:0]  sq_cnt;
		logic        sq_lvl;
		logic [63:0] word;
	} brt_eng_t;
endpackage : brt_pkg

// *** src/brt_pattern_engine.sv ***
// Test pattern engine producing one 64-bit word per clock
`timescale 1ns/1ps
`default_nettype none
module brt_pattern_engine
	import brt_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// Control
	input  wire logic        restart,
	input  wire brt_pat_t    mode,
	input  wire logic [3:0]  square_period,
	input  wire logic        no_invert,
	input  wire logic [57:0] seed_a,
	input  wire logic [57:0] seed_b,
	input  wire logic [63:0] data_pat,
	// Pattern
	output logic      [63:0] word
);
	brt_eng_t s, n;
	logic [121:0] r;
	logic [57:0]  base;
	logic [63:0]  dp;

	// Serial 1+x^39+x^58 scrambler run over 64 bits, low bit first
	function automatic logic [121:0] brt_scr(input logic [57:0] st, input logic [63:0] d);
		logic [57:0] t;
		logic [63:0] o;
		logic        b;
		t = st;
		o = '0;
		for (int i = 0; i < 64; i++) begin
			b = d[i] ^ t[38] ^ t[57];
			o[i] = b;
			t = {t[56:0], b};
		end
		return {t, o};
	endfunction : brt_scr

	always_comb begin
		n = s;
		r = '0;
		base = '0;
		dp = data_pat;
		if (restart) begin
			n.scr = seed_a;
			n.blk = '0;
			n.phase = '0;
			n.prbs = '1;
			n.sq_cnt = '0;
			n.sq_lvl = 1'b1;
			n.word = '0;
		end else begin
			case (mode)
				BRT_PAT_SQUARE: begin
					n.word = {64{s.sq_lvl}};
					if (s.sq_cnt == square_period) begin
						n.sq_cnt = '0;
						n.sq_lvl = !s.sq_lvl;
					end else begin
						n.sq_cnt = s.sq_cnt + 4'h1;
					end
				end
				BRT_PAT_PRBS31: begin
					for (int i = 0; i < 64; i++) begin
						n.prbs = {n.prbs[29:0], n.prbs[30] ^ n.prbs[27]};
						n.word[i] = n.prbs[0];
					end
				end
				BRT_PAT_PSEUDO: begin
					if (s.phase[0] && !no_invert) begin
						dp = ~data_pat;
					end
					r = brt_scr(s.scr, dp);
					n.word = r[63:0];
					n.scr = r[121:64];
					n.blk = s.blk + 7'h01;
					if (s.blk == 7'h7F) begin
						// Window boundary: seeds A, ~A, B, ~B in turn
						n.phase = s.phase + 2'h1;
						base = n.phase[1] ? seed_b : seed_a;
						n.scr = (n.phase[0] && !no_invert) ? ~base : base;
					end
				end
				default: begin
					// User pattern free-runs the scrambler, reseeded with seed A only on restart
					r = brt_scr(s.scr, data_pat);
					n.word = r[63:0];
					n.scr = r[121:64];
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign word = s.word;
endmodule : brt_pattern_engine
`default_nettype wire

// *** src/brt_coding_ctrl.sv ***
// Coding sublayer test, loopback, signal detect and correction control with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "brt_regs.svh"
module brt_coding_ctrl
	import brt_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// AXI4-Lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Signal detect
	input  wire logic        sd_serdes,
	input  wire logic        sd_module_pin,
	output logic             rx_restart,
	output logic             rx_frame_en,
	// Data paths
	input  wire logic [63:0] tx_data_in,
	output logic [63:0]      tx_data_out,
	input  wire logic [63:0] rx_data_in,
	output logic [63:0]      rx_data_out,
	// Forward error correction
	input  wire logic        fec_lock,
	input  wire logic        fec_fixed_blk,
	input  wire logic        fec_unfixed_blk,
	output logic             fwd_corr_on,
	output logic             tx_flip,
	output logic             rx_flip,
	output logic             rx_blk_err,
	// Low power idle
	input  wire logic        lpi_tx_active,
	input  wire logic        lpi_rx_active,
	input  wire logic        wake_err
);
	typedef struct packed {
		brt_wst_t    wst;
		logic        aw_have;
		logic        w_have;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [2:0]  sd_cfg;
		logic [2:0]  cc;
		logic [9:0]  tcfg;
		logic [25:0] seed_au;
		logic [31:0] seed_al;
		logic [25:0] seed_bu;
		logic [31:0] seed_bl;
		logic [63:0] txp;
		logic [63:0] rxp;
		logic [31:0] err_cnt;
		logic [31:0] wake_cnt;
		logic [1:0]  lpi;
		logic [4:0]  fcfg;
		logic [2:0]  flags;
		logic [31:0] fix_cnt;
		logic [31:0] unf_cnt;
		logic [31:0] fix_lim;
		logic [31:0] unf_lim;
		logic        lock_q;
		logic        rc_q;
		logic        match;
		logic        sig_ok;
		logic        rx_restart;
		logic        rx_frame_en;
		logic        blk_err;
		logic [63:0] tx_out;
		logic [63:0] rx_out;
	} brt_ctrl_t;

	brt_ctrl_t   s, n;
	logic [63:0] gen_word;
	logic [63:0] chk_word;
	logic        sd_line;
	logic [63:0] rx_src;
	logic        mis;
	logic [31:0] wm;
	logic [31:0] wv;
	logic [31:0] rd;
	logic        rd_ok;
	logic        wr_ok;
	logic        wr_go;

	// Generator and checker are held at their start while their test bit is off
	brt_pattern_engine gen_i (
		.sys_clk       (sys_clk),
		.sys_rst       (sys_rst),
		.restart       (!s.cc[`BRT_F_TX_TEST]),
		.mode          (brt_pat_t'(s.tcfg[1:0])),
		.square_period (s.tcfg[7:4]),
		.no_invert     (s.tcfg[8]),
		.seed_a        ({s.seed_au, s.seed_al}),
		.seed_b        ({s.seed_bu, s.seed_bl}),
		.data_pat      (s.txp),
		.word          (gen_word)
	);

	brt_pattern_engine chk_i (
		.sys_clk       (sys_clk),
		.sys_rst       (sys_rst),
		.restart       (!s.cc[`BRT_F_RX_TEST]),
		.mode          (brt_pat_t'(s.tcfg[3:2])),
		.square_period (s.tcfg[7:4]),
		.no_invert     (s.tcfg[9]),
		.seed_a        ({s.seed_au, s.seed_al}),
		.seed_b        ({s.seed_bu, s.seed_bl}),
		.data_pat      (s.rxp),
		.word          (chk_word)
	);

	always_comb begin
		n = s;
		wm = '0;
		wv = '0;
		rd = '0;
		rd_ok = 1'b1;
		wr_ok = 1'b1;
		wr_go = 1'b0;
		for (int b = 0; b < 4; b++) begin
			wm[b*8 +: 8] = {8{s.wstrb[b]}};
		end
		// Signal detect
		sd_line = s.sd_cfg[`BRT_F_SD_SRC] ? sd_module_pin : sd_serdes;
		n.sig_ok = (sd_line == s.sd_cfg[`BRT_F_DET_LEVEL]);
		n.rx_restart = s.sd_cfg[`BRT_F_SD_REACT] && !n.sig_ok;
		n.rx_frame_en = !n.rx_restart;
		// Data paths
		n.tx_out = s.cc[`BRT_F_TX_TEST] ? gen_word : tx_data_in;
		rx_src = s.cc[`BRT_F_LOOP] ? s.tx_out : rx_data_in;
		n.rx_out = rx_src;
		n.match = s.cc[`BRT_F_RX_TEST] && (rx_src == chk_word);
		mis = s.cc[`BRT_F_RX_TEST] && (rx_src != chk_word);
		// AXI4-Lite write channel: address and data accepted in either order
		if (s_axi_awvalid && s.awready) begin
			n.aw_have = 1'b1;
			n.awaddr = s_axi_awaddr;
			n.awready = 1'b0;
		end
		if (s_axi_wvalid && s.wready) begin
			n.w_have = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
			n.wready = 1'b0;
		end
		case (s.wst)
			BRT_W_IDLE: begin
				if (s.aw_have && s.w_have) begin
					wr_go = 1'b1;
					n.aw_have = 1'b0;
					n.w_have = 1'b0;
					n.bvalid = 1'b1;
					n.wst = BRT_W_RESP;
				end
			end
			BRT_W_RESP: begin
				if (s_axi_bready) begin
					n.bvalid = 1'b0;
					n.awready = 1'b1;
					n.wready = 1'b1;
					n.wst = BRT_W_IDLE;
				end
			end
			default: n.wst = BRT_W_IDLE;
		endcase
		if (wr_go) begin
			case (s.awaddr)
				`BRT_A_SD_CFG:     wv = {29'h0, s.sd_cfg};
				`BRT_A_CODING_CFG: wv = {29'h0, s.cc};
				`BRT_A_PAT_CFG:    wv = {22'h0, s.tcfg};
				`BRT_A_SEED_AU:    wv = {6'h0, s.seed_au};
				`BRT_A_SEED_AL:    wv = s.seed_al;
				`BRT_A_SEED_BU:    wv = {6'h0, s.seed_bu};
				`BRT_A_SEED_BL:    wv = s.seed_bl;
				`BRT_A_TXP_U:      wv = s.txp[63:32];
				`BRT_A_TXP_L:      wv = s.txp[31:0];
				`BRT_A_RXP_U:      wv = s.rxp[63:32];
				`BRT_A_RXP_L:      wv = s.rxp[31:0];
				`BRT_A_ERR_CNT:    wv = s.err_cnt;
				`BRT_A_FC_CFG:     wv = {27'h0, s.fcfg};
				`BRT_A_FC_FLAGS:   wv = 32'h0000_0000;
				`BRT_A_FIX_LIM:    wv = s.fix_lim;
				`BRT_A_UNF_LIM:    wv = s.unf_lim;
				default:           wr_ok = 1'b0;
			endcase
			wv = (wv & ~wm) | (s.wdata & wm);
			n.bresp = wr_ok ? `BRT_RESP_OKAY : `BRT_RESP_SLVERR;
			case (s.awaddr)
				`BRT_A_SD_CFG:     n.sd_cfg = wv[2:0];
				`BRT_A_CODING_CFG: n.cc = wv[2:0];
				`BRT_A_PAT_CFG:    n.tcfg = wv[9:0];
				`BRT_A_SEED_AU:    n.seed_au = wv[25:0];
				`BRT_A_SEED_AL:    n.seed_al = wv;
				`BRT_A_SEED_BU:    n.seed_bu = wv[25:0];
				`BRT_A_SEED_BL:    n.seed_bl = wv;
				`BRT_A_TXP_U:      n.txp[63:32] = wv;
				`BRT_A_TXP_L:      n.txp[31:0] = wv;
				`BRT_A_RXP_U:      n.rxp[63:32] = wv;
				`BRT_A_RXP_L:      n.rxp[31:0] = wv;
				`BRT_A_ERR_CNT:    n.err_cnt = wv;
				`BRT_A_FC_CFG:     n.fcfg = wv[4:0];
				`BRT_A_FC_FLAGS:   n.flags = s.flags & ~wv[2:0];
				`BRT_A_FIX_LIM:    n.fix_lim = wv;
				`BRT_A_UNF_LIM:    n.unf_lim = wv;
				default:           n.bresp = `BRT_RESP_SLVERR;
			endcase
		end
		// AXI4-Lite read channel
		if (s_axi_arvalid && s.arready) begin
			case (s_axi_araddr)
				`BRT_A_SD_CFG:     rd = {29'h0, s.sd_cfg};
				`BRT_A_CODING_CFG: rd = {29'h0, s.cc};
				`BRT_A_CODING_ST:  rd = {30'h0, s.sig_ok, s.match};
				`BRT_A_PAT_CFG:    rd = {22'h0, s.tcfg};
				`BRT_A_SEED_AU:    rd = {6'h0, s.seed_au};
				`BRT_A_SEED_AL:    rd = s.seed_al;
				`BRT_A_SEED_BU:    rd = {6'h0, s.seed_bu};
				`BRT_A_SEED_BL:    rd = s.seed_bl;
				`BRT_A_TXP_U:      rd = s.txp[63:32];
				`BRT_A_TXP_L:      rd = s.txp[31:0];
				`BRT_A_RXP_U:      rd = s.rxp[63:32];
				`BRT_A_RXP_L:      rd = s.rxp[31:0];
				`BRT_A_ERR_CNT:    rd = s.err_cnt;
				`BRT_A_LPI_ST:     rd = {30'h0, s.lpi};
				`BRT_A_WAKE_CNT:   rd = s.wake_cnt;
				`BRT_A_FC_CFG:     rd = {27'h0, s.fcfg};
				`BRT_A_FC_ST:      rd = {31'h0, s.lock_q};
				`BRT_A_FC_FLAGS:   rd = {29'h0, s.flags};
				`BRT_A_FIX_CNT:    rd = s.fix_cnt;
				`BRT_A_UNF_CNT:    rd = s.unf_cnt;
				`BRT_A_FIX_LIM:    rd = s.fix_lim;
				`BRT_A_UNF_LIM:    rd = s.unf_lim;
				default:           rd_ok = 1'b0;
			endcase
			n.rdata = rd;
			n.rresp = rd_ok ? `BRT_RESP_OKAY : `BRT_RESP_SLVERR;
			n.rvalid = 1'b1;
			n.arready = 1'b0;
		end else if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
			n.arready = 1'b1;
		end
		// Events come after the bus write so a same-cycle event beats a bus clear, but the fix_cnt and unf_cnt reset beats a block event
		n.err_cnt = n.err_cnt + {31'h0, mis};
		n.lpi = {lpi_tx_active, lpi_rx_active};
		if (wake_err && s.wake_cnt != 32'hFFFF_FFFF) begin
			n.wake_cnt = s.wake_cnt + 32'h0000_0001;
		end
		n.lock_q = fec_lock;
		if (s.lock_q && !fec_lock) begin
			n.flags[`BRT_F_LOCK_FLAG] = 1'b1;
		end
		n.rc_q = s.fcfg[`BRT_F_FC_CNTRST];
		if (s.rc_q && !s.fcfg[`BRT_F_FC_CNTRST]) begin
			n.fix_cnt = '0;
			n.unf_cnt = '0;
		end else begin
			// Counters saturate rather than wrap so a limit is never crossed twice
			if (fec_fixed_blk && s.fix_cnt != 32'hFFFF_FFFF) begin
				n.fix_cnt = s.fix_cnt + 32'h0000_0001;
				if (s.fix_cnt == s.fix_lim) begin
					n.flags[`BRT_F_FIX_FLAG] = 1'b1;
				end
			end
			if (fec_unfixed_blk && s.unf_cnt != 32'hFFFF_FFFF) begin
				n.unf_cnt = s.unf_cnt + 32'h0000_0001;
				if (s.unf_cnt == s.unf_lim) begin
					n.flags[`BRT_F_UNF_FLAG] = 1'b1;
				end
			end
		end
		n.blk_err = s.fcfg[`BRT_F_FC_ERRIND] && fec_unfixed_blk;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
			s.wst <= BRT_W_IDLE;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
			s.sd_cfg <= `BRT_RST_SD_CFG;
			s.fix_lim <= `BRT_RST_LIMIT;
			s.unf_lim <= `BRT_RST_LIMIT;
			s.rx_frame_en <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rdata = s.rdata;
	assign rx_restart = s.rx_restart;
	assign rx_frame_en = s.rx_frame_en;
	assign tx_data_out = s.tx_out;
	assign rx_data_out = s.rx_out;
	assign fwd_corr_on = s.fcfg[`BRT_F_FC_ON];
	assign tx_flip = s.fcfg[`BRT_F_FC_TXFLIP];
	assign rx_flip = s.fcfg[`BRT_F_FC_RXFLIP];
	assign rx_blk_err = s.blk_err;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	loss_restart_a: assert property (s.sd_cfg[0] && !n.sig_ok |=> rx_restart && !rx_frame_en)
		else $error("loss of signal did not restart receive");
	no_react_a: assert property (!s.sd_cfg[0] |=> rx_frame_en && !rx_restart)
		else $error("receive stopped with reaction disabled");
	polarity_a: assert property ((sd_line == s.sd_cfg[1]) |=> s.sig_ok)
		else $error("signal detect polarity ignored");
	loop_path_a: assert property (s.cc[0] |=> rx_data_out == $past(tx_data_out))
		else $error("loopback did not carry transmit data");
	match_bit_a: assert property (s.cc[2] && rx_src != chk_word |=> !s.match)
		else $error("match bit high on mismatch");
	err_count_a: assert property (mis && !wr_go |=> s.err_cnt == $past(s.err_cnt) + 32'h1)
		else $error("pattern error not counted");
	lock_flag_a: assert property ($fell(fec_lock) ##1 !$past(wr_go) |-> s.flags[0])
		else $error("frame lock loss not flagged");
	cnt_clear_a: assert property ($fell(s.fcfg[4]) |=> s.fix_cnt == 0 && s.unf_cnt == 0)
		else $error("block counters not cleared");
	sticky_hold_a: assert property (s.flags[1] && !wr_go |=> s.flags[1])
		else $error("sticky flag dropped without clear");
	blk_err_a: assert property (s.fcfg[3] && fec_unfixed_blk |=> rx_blk_err)
		else $error("uncorrectable block not signalled");
endmodule : brt_coding_ctrl
`default_nettype wire

// *** tb/brt_pma_model.sv ***
// Far-side model: serdes detect, optical module detect, line echo and correction lock
`timescale 1ns/1ps
`default_nettype none
module brt_pma_model (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// Scenario control
	input  wire logic        light_serdes,
	input  wire logic        light_module,
	input  wire logic        lock_want,
	// Line side
	input  wire logic [63:0] tx_line,
	output logic             sd_serdes,
	output logic             sd_module_pin,
	output logic             fec_lock,
	output logic [63:0]      rx_line
);
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sd_serdes     <= 1'h1;
			sd_module_pin <= 1'h1;
			fec_lock      <= 1'h0;
			rx_line       <= '0;
		end else begin
			sd_serdes     <= light_serdes;
			sd_module_pin <= light_module;
			fec_lock      <= lock_want;
			// Echo is inverted so that a missing loopback cannot pass for one;
			// without light the line inverts its previous word on every clock
			rx_line       <= light_serdes ? ~tx_line : ~rx_line;
		end
	end
endmodule : brt_pma_model
`default_nettype wire

// *** tb/brt_coding_ctrl_test.sv ***
// Self-checking bench for the coding control block
`timescale 1ns/1ps
`default_nettype none
`include "brt_regs.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module brt_coding_ctrl_test;
	logic        sys_clk, sys_rst;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        sd_serdes, sd_module_pin, rx_restart, rx_frame_en;
	logic [63:0] tx_data_in, tx_data_out, rx_data_in, rx_data_out;
	logic        fec_lock, fec_fixed_blk, fec_unfixed_blk, fwd_corr_on, tx_flip, rx_flip;
	logic        rx_blk_err, lpi_tx_active, lpi_rx_active, wake_err;
	logic        light_serdes, light_module, lock_want, lvl, ex;
	logic [2:0]  cfg;
	int          err_total, checked, cycles;

	brt_coding_ctrl uut (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .sd_serdes, .sd_module_pin, .rx_restart, .rx_frame_en,
		.tx_data_in, .tx_data_out, .rx_data_in, .rx_data_out, .fec_lock, .fec_fixed_blk,
		.fec_unfixed_blk, .fwd_corr_on, .tx_flip, .rx_flip, .rx_blk_err, .lpi_tx_active,
		.lpi_rx_active, .wake_err);
	brt_pma_model pma (.sys_clk, .sys_rst, .light_serdes, .light_module, .lock_want,
		.tx_line(tx_data_out), .sd_serdes, .sd_module_pin, .fec_lock, .rx_line(rx_data_in));

	initial begin
		sys_clk = 1'h0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	// A hang anywhere lands here as a mismatch
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			print_verdict();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_on, w_on;
		@(posedge sys_clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		s_axi_bready  <= 1'h1;
		aw_on = 1'h1;
		w_on = 1'h1;
		while (aw_on || w_on) begin
			@(posedge sys_clk);
			if (aw_on && s_axi_awready === 1'h1) begin
				aw_on = 1'h0;
				s_axi_awvalid <= 1'h0;
			end
			if (w_on && s_axi_wready === 1'h1) begin
				w_on = 1'h0;
				s_axi_wvalid <= 1'h0;
			end
		end
		while (s_axi_bvalid !== 1'h1) @(posedge sys_clk);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		@(posedge sys_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready  <= 1'h1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		while (s_axi_rvalid !== 1'h1) @(posedge sys_clk);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : rdr

	task automatic chk(input logic [7:0] a, input logic [31:0] e, input string nm);
		rdr(a);
		`CHK(nm, e, rd)
	endtask : chk

	// Kind 0 fixed block, 1 unfixed block, 2 wake error
	task automatic pulse(input int kind, input int n);
		repeat (n) begin
			@(posedge sys_clk);
			fec_fixed_blk   <= (kind == 0);
			fec_unfixed_blk <= (kind == 1);
			wake_err        <= (kind == 2);
			@(posedge sys_clk);
			fec_fixed_blk   <= 1'h0;
			fec_unfixed_blk <= 1'h0;
			wake_err        <= 1'h0;
		end
	endtask : pulse

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	initial begin
		sys_rst = 1'h1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, tx_data_in, lock_want} = '0;
		{fec_fixed_blk, fec_unfixed_blk, lpi_tx_active, lpi_rx_active, wake_err} = '0;
		s_axi_wstrb = 4'hF;
		light_serdes = 1'h1;
		light_module = 1'h1;
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'h0;
		chk(`BRT_A_SD_CFG, 32'h0000_0003, "detect config at reset");
		chk(`BRT_A_FIX_LIM, 32'h0000_0100, "fixed limit at reset");
		chk(`BRT_A_UNF_LIM, 32'h0000_0100, "unfixed limit at reset");
		chk(`BRT_A_CODING_CFG, 32'h0000_0000, "coding config at reset");
		chk(8'h58, 32'h0000_0000, "unmapped read data");
		`CHK("unmapped read response", `BRT_RESP_SLVERR, rsp)
		wr(8'h58, 32'hFFFF_FFFF);
		`CHK("unmapped write response", `BRT_RESP_SLVERR, rsp)
		for (int i = 0; i < 16; i++) begin
			cfg = i[2:0];
			lvl = i[3];
			wr(`BRT_A_SD_CFG, {29'h0000_0000, cfg});
			light_serdes <= lvl;
			light_module <= ~lvl;
			tick(4);
			ex = cfg[0] && ((cfg[2] ? ~lvl : lvl) != cfg[1]);
			`CHK("receive restart", ex, rx_restart)
			`CHK("frame reception", ~ex, rx_frame_en)
		end
		wr(`BRT_A_SD_CFG, 32'h0000_0003);
		light_serdes <= 1'h1;
		light_module <= 1'h1;
		wr(`BRT_A_CODING_CFG, 32'h0000_0001);
		tx_data_in <= 64'h0123_4567_89AB_CDEF;
		tick(4);
		`CHK("transmit word", 64'h0123_4567_89AB_CDEF, tx_data_out)
		`CHK("looped receive word", 64'h0123_4567_89AB_CDEF, rx_data_out)
		wr(`BRT_A_CODING_CFG, 32'h0000_0000);
		tick(4);
		`CHK("line receive word", ~64'h0123_4567_89AB_CDEF, rx_data_out)
		wr(`BRT_A_CODING_CFG, 32'h0000_0006);
		chk(`BRT_A_CODING_CFG, 32'h0000_0006, "test mode bits");
		wr(`BRT_A_CODING_CFG, 32'h0000_0000);
		// Generator and checker get different codes to show the fields are independent
		for (int p = 0; p < 4; p++) begin
			wr(`BRT_A_PAT_CFG, {22'h00_0000, 2'h3, 4'hE, 2'(3 - p), 2'(p)});
			chk(`BRT_A_PAT_CFG, {22'h00_0000, 2'h3, 4'hE, 2'(3 - p), 2'(p)}, "pattern config");
			// Run both engines briefly in this mode so the checker assertions see it
			wr(`BRT_A_CODING_CFG, 32'h0000_0006);
			wr(`BRT_A_CODING_CFG, 32'h0000_0000);
		end
		wr(`BRT_A_SEED_AU, 32'hFFFF_FFFF);
		chk(`BRT_A_SEED_AU, 32'h03FF_FFFF, "seed a upper");
		wr(`BRT_A_SEED_BL, 32'hA5A5_5A5A);
		chk(`BRT_A_SEED_BL, 32'hA5A5_5A5A, "seed b lower");
		wr(`BRT_A_RXP_U, 32'h1357_9BDF);
		chk(`BRT_A_RXP_U, 32'h1357_9BDF, "receive pattern upper");
		wr(`BRT_A_ERR_CNT, 32'h0000_0005);
		chk(`BRT_A_ERR_CNT, 32'h0000_0005, "pattern errors written");
		wr(`BRT_A_ERR_CNT, 32'h0000_0000);
		chk(`BRT_A_ERR_CNT, 32'h0000_0000, "pattern errors cleared");
		lpi_rx_active <= 1'h1;
		pulse(2, 2);
		chk(`BRT_A_LPI_ST, 32'h0000_0001, "low power status");
		wr(`BRT_A_WAKE_CNT, 32'h0000_0009);
		`CHK("read-only write response", `BRT_RESP_SLVERR, rsp)
		chk(`BRT_A_WAKE_CNT, 32'h0000_0002, "wake errors");
		// Receive low power is left active here, and correction is switched on regardless
		wr(`BRT_A_FC_CFG, 32'h0000_000F);
		tick(1);
		`CHK("correction on", 3'h7, {fwd_corr_on, tx_flip, rx_flip})
		pulse(1, 1);
		#1;
		`CHK("uncorrectable indication", 1'h1, rx_blk_err)
		@(posedge sys_clk);
		lock_want <= 1'h1;
		tick(4);
		chk(`BRT_A_FC_ST, 32'h0000_0001, "frame lock");
		lock_want <= 1'h0;
		wr(`BRT_A_FIX_LIM, 32'h0000_0002);
		pulse(0, 2);
		chk(`BRT_A_FC_FLAGS, 32'h0000_0001, "flags at limit");
		pulse(0, 1);
		chk(`BRT_A_FC_FLAGS, 32'h0000_0003, "flags past limit");
		chk(`BRT_A_UNF_CNT, 32'h0000_0001, "unfixed count");
		wr(`BRT_A_UNF_LIM, 32'h0000_0001);
		pulse(1, 1);
		chk(`BRT_A_FC_FLAGS, 32'h0000_0007, "unfixed flag past limit");
		wr(`BRT_A_FC_FLAGS, 32'h0000_0001);
		chk(`BRT_A_FC_FLAGS, 32'h0000_0006, "lock flag cleared");
		wr(`BRT_A_FC_FLAGS, 32'h0000_0000);
		chk(`BRT_A_FC_FLAGS, 32'h0000_0006, "flag kept on zero");
		wr(`BRT_A_FC_CFG, 32'h0000_001F);
		chk(`BRT_A_FIX_CNT, 32'h0000_0003, "fixed count held");
		wr(`BRT_A_FC_CFG, 32'h0000_000F);
		chk(`BRT_A_FIX_CNT, 32'h0000_0000, "fixed count cleared");
		chk(`BRT_A_UNF_CNT, 32'h0000_0000, "unfixed count cleared");
		print_verdict();
	end
endmodule : brt_coding_ctrl_test
`default_nettype wire
